/* File: rtl/ripple_counter_pkg.sv */
// constants and types for the presettable ripple counter with latch mode
`default_nettype none
package ripple_counter_pkg;
   localparam int STAGE_COUNT = 4;
   localparam int CHAIN_WIDTH = 3;
   localparam logic [3:0] OUT_RESET = 4'h0;
   localparam logic [2:0] QUINARY_LAST = 3'h4;
   localparam logic [2:0] CHAIN_ZERO = 3'h0;
   localparam logic [2:0] CHAIN_ONE = 3'h1;
   localparam logic DECADE_VARIANT = 1'b1;
   localparam logic BINARY_VARIANT = 1'b0;
   localparam int EDGE_HIST = 2;
   // one line of activity of the upper chain
   typedef enum logic [1:0] {
      ACT_HOLD = 2'b00,
      ACT_CLEAR = 2'b01,
      ACT_LOAD = 2'b10,
      ACT_COUNT = 2'b11
   } chain_act_t;
endpackage
`default_nettype wire

/* File: rtl/fall_detect.sv */
// falling edge detector for one sampled clock input
`default_nettype none
module fall_detect (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic level_in, // sampled clock input
   output logic fall // one-cycle pulse on a high-to-low step
);
   logic prev_r;

   // follow the pin every cycle, reset too, so a low pin at release fakes no fall
   always_ff @(posedge clk) begin
      prev_r <= level_in;
   end

   // pulse only on a falling step, never while in reset
   assign fall = prev_r & ~level_in & ~rst;
endmodule
`default_nettype wire

/* File: rtl/presettable_ripple_counter_latch.sv */
// four-stage presettable ripple counter with transparent latch mode
`default_nettype none
module presettable_ripple_counter_latch #(
   parameter logic VARIANT = ripple_counter_pkg::DECADE_VARIANT // 1 decade, 0 binary
) (
   input wire logic clk, // system clock, 10 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic count_clk1, // first count clock, falls to count
   input wire logic count_clk2, // second count clock, falls to count
   input wire logic load_n, // load strobe, active low
   input wire logic clear_n, // clear, active low
   input wire logic [ripple_counter_pkg::STAGE_COUNT-1:0] data_in, // preset data
   output logic stage0_out, // halver output
   output logic stage1_out, // chain bit 0
   output logic stage2_out, // chain bit 1
   output logic stage3_out // chain bit 2
);
   import ripple_counter_pkg::*;

   // refuse any layout other than one halver and a three-bit chain
   if (STAGE_COUNT != 4 || CHAIN_WIDTH != 3) begin
      $error("stage layout must be one halver and a three-bit chain");
   end

   logic fall1;
   logic fall2;
   logic [CHAIN_WIDTH-1:0] chain_r;
   logic [CHAIN_WIDTH-1:0] chain_nxt;
   logic half_r;
   chain_act_t act;

   // falling edge detectors, one for each clock input
   fall_detect u_fall1 (
      .clk(clk),
      .rst(rst),
      .level_in(count_clk1),
      .fall(fall1)
   );
   fall_detect u_fall2 (
      .clk(clk),
      .rst(rst),
      .level_in(count_clk2),
      .fall(fall2)
   );

   // chain activity; clear outranks load, load outranks counting
   always_comb begin
      if (!clear_n) begin
         act = ACT_CLEAR;
      end else if (!load_n) begin
         act = ACT_LOAD;
      end else if (fall2) begin
         act = ACT_COUNT;
      end else begin
         act = ACT_HOLD;
      end
   end

   // next chain count: modulo five or modulo eight
   always_comb begin
      chain_nxt = chain_r + CHAIN_ONE;
      if (VARIANT == DECADE_VARIANT && chain_r >= QUINARY_LAST) begin
         chain_nxt = CHAIN_ZERO;
      end
   end

   // upper three stages, clocked only by the second clock
   always_ff @(posedge clk) begin
      if (rst) begin
         chain_r <= OUT_RESET[CHAIN_WIDTH:1];
      end else begin
         unique case (act)
            ACT_CLEAR: chain_r <= CHAIN_ZERO;
            ACT_LOAD: chain_r <= data_in[CHAIN_WIDTH:1];
            ACT_COUNT: chain_r <= chain_nxt;
            ACT_HOLD: chain_r <= chain_r;
         endcase
      end
   end

   // first stage: toggles on first clock only, shares load and clear
   always_ff @(posedge clk) begin
      if (rst) begin
         half_r <= OUT_RESET[0];
      end else if (!clear_n) begin
         half_r <= 1'b0;
      end else if (!load_n) begin
         half_r <= data_in[0];
      end else if (fall1) begin
         half_r <= ~half_r;
      end
   end

   // outputs come straight from the stage flip-flops
   assign stage0_out = half_r;
   assign stage1_out = chain_r[0];
   assign stage2_out = chain_r[1];
   assign stage3_out = chain_r[2];

   // clear low drives all outputs low on the next edge
   clear_forces_low_a: assert property (@(posedge clk) disable iff (rst)
      !clear_n |=> {stage3_out, stage2_out, stage1_out, stage0_out} == 4'h0)
      else $error("clear did not force outputs low");

   // load low alone copies data on the next edge
   load_copies_data_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && !load_n |=>
         {stage3_out, stage2_out, stage1_out, stage0_out} == $past(data_in))
      else $error("load did not copy data");

   // both low gives zero, never data
   clear_beats_load_a: assert property (@(posedge clk) disable iff (rst)
      !clear_n && !load_n |=> {stage3_out, stage2_out, stage1_out, stage0_out} == 4'h0)
      else $error("load won over clear");

   // no edge and strobe high: held
   latch_holds_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && !fall1 && !fall2 |=> $stable({chain_r, half_r}))
      else $error("latch did not hold");

   // first stage toggles on a first-clock fall
   half_toggles_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && fall1 |=> half_r != $past(half_r))
      else $error("first stage missed its falling edge");

   // first clock never moves the chain
   chain_isolated_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && !fall2 |=> $stable(chain_r))
      else $error("chain moved without second clock");

   // chain advances by one, wrapping per variant
   chain_steps_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && fall2 |=> chain_r == ((VARIANT == DECADE_VARIANT
         && $past(chain_r) >= QUINARY_LAST) ? CHAIN_ZERO : $past(chain_r) + CHAIN_ONE))
      else $error("chain step wrong");

   // decade chain never leaves zero..four after counting from range
   quinary_range_a: assert property (@(posedge clk) disable iff (rst)
      VARIANT == DECADE_VARIANT && clear_n && load_n && fall2
         && chain_r <= QUINARY_LAST |=> chain_r <= QUINARY_LAST)
      else $error("five-counter left its range");

   // first stage moves only on a first-clock fall
   halver_own_clock_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && !fall1
      |=> $stable(half_r))
      else $error("first stage moved without first clock");

   // load wins over any clock fall in the same cycle
   load_beats_falls_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && !load_n && (fall1 || fall2)
      |=> {stage3_out, stage2_out, stage1_out, stage0_out} == $past(data_in))
      else $error("clock fall disturbed a load");

   // clear wins over any clock fall in the same cycle
   clear_beats_falls_a: assert property (@(posedge clk) disable iff (rst)
      !clear_n && (fall1 || fall2)
      |=> {stage3_out, stage2_out, stage1_out, stage0_out} == 4'h0)
      else $error("clock fall disturbed a clear");

   // every counted second-clock fall moves the chain
   chain_counts_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && fall2
      |=> $changed(chain_r))
      else $error("chain ignored a falling edge");

   // five-counter wraps from four to zero
   quinary_wrap_a: assert property (@(posedge clk) disable iff (rst)
      VARIANT == DECADE_VARIANT && clear_n && load_n && fall2 && chain_r == QUINARY_LAST
      |=> chain_r == CHAIN_ZERO)
      else $error("five-counter missed its wrap");

   // five-counter wrap gives a falling top bit
   quinary_carry_a: assert property (@(posedge clk) disable iff (rst)
      VARIANT == DECADE_VARIANT && clear_n && load_n && fall2 && chain_r == QUINARY_LAST
      |=> $fell(stage3_out))
      else $error("top bit did not fall on five-counter wrap");

   // loaded codes above four return to zero on a count
   illegal_to_zero_a: assert property (@(posedge clk) disable iff (rst)
      VARIANT == DECADE_VARIANT && clear_n && load_n && fall2 && chain_r > QUINARY_LAST
      |=> chain_r == CHAIN_ZERO)
      else $error("five-counter kept an unused code");

   // eight-counter wraps from seven to zero
   binary_wrap_a: assert property (@(posedge clk) disable iff (rst)
      VARIANT == BINARY_VARIANT && clear_n && load_n && fall2 && (&chain_r)
      |=> chain_r == CHAIN_ZERO)
      else $error("eight-counter missed its wrap");

   // eight-counter wrap gives a falling top bit
   binary_carry_a: assert property (@(posedge clk) disable iff (rst)
      VARIANT == BINARY_VARIANT && clear_n && load_n && fall2 && (&chain_r)
      |=> $fell(stage3_out))
      else $error("top bit did not fall on eight-counter wrap");

   // first stage toggling from high gives a falling output
   half_carry_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && load_n && fall1 && half_r
      |=> $fell(stage0_out))
      else $error("first stage output did not fall");

   // closing the latch strobe keeps the last value
   latch_closes_a: assert property (@(posedge clk) disable iff (rst)
      clear_n && $rose(load_n) && !fall1 && !fall2
      |=> $stable({stage3_out, stage2_out, stage1_out, stage0_out}))
      else $error("latch changed as the strobe closed");
endmodule
`default_nettype wire

/* File: tb/count_wiring.sv */
// external wiring around the counter: pulse sources or stage feedback
`default_nettype none
module count_wiring (
   input wire logic [1:0] mode, // 0 free, 1 stage0 to clk2, 2 stage3 to clk1
   input wire logic pulse1, // pulses for first clock
   input wire logic pulse2, // pulses for second clock
   input wire logic s0, // stage0 feedback
   input wire logic s3, // stage3 feedback
   output logic clk1, // first count clock
   output logic clk2 // second count clock
);
   timeunit 1ns;
   timeprecision 1ns;
   // route feedback as the chosen mode wires it
   assign clk1 = (mode == 2'h2) ? s3 : pulse1;
   assign clk2 = (mode == 2'h1) ? s0 : pulse2;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the counter in decade and binary builds
`default_nettype none
module tb_top import ripple_counter_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, p1 = 1, p2 = 1, load_n = 1, clear_n = 1;
   logic [1:0] m = 2'h0;
   logic [3:0] d = 4'h0, ed = 4'h0, eb = 4'h0, r;
   logic [31:0] seed = 32'h61;
   wire [3:0] qd, qb;
   wire dk1, dk2, bk1, bk2;
   int num_errors = 0, tests_run = 0;
   // clock generation
   initial forever #50 clk = ~clk;
   count_wiring u_wd (.mode(m), .pulse1(p1), .pulse2(p2), .s0(qd[0]), .s3(qd[3]), .clk1(dk1),
      .clk2(dk2));
   count_wiring u_wb (.mode(m), .pulse1(p1), .pulse2(p2), .s0(qb[0]), .s3(qb[3]), .clk1(bk1),
      .clk2(bk2));
   presettable_ripple_counter_latch #(.VARIANT(DECADE_VARIANT)) u_dut (.clk(clk), .rst(rst),
      .count_clk1(dk1), .count_clk2(dk2), .load_n(load_n), .clear_n(clear_n), .data_in(d),
      .stage0_out(qd[0]), .stage1_out(qd[1]), .stage2_out(qd[2]), .stage3_out(qd[3]));
   presettable_ripple_counter_latch #(.VARIANT(BINARY_VARIANT)) u_bin (.clk(clk), .rst(rst),
      .count_clk1(bk1), .count_clk2(bk2), .load_n(load_n), .clear_n(clear_n), .data_in(d),
      .stage0_out(qb[0]), .stage1_out(qb[1]), .stage2_out(qb[2]), .stage3_out(qb[3]));
   // xorshift source
   function logic [3:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[3:0];
   endfunction
   // next state after one pulse under the current wiring
   function automatic logic [3:0] step(input logic dec, input logic on1, input logic [3:0] q);
      logic [2:0] c;
      logic b;
      c = q[3:1];
      b = q[0] ^ on1;
      if (!on1 || (m == 2'h1 && q[0]))
         c = (dec && c >= 3'h4) ? 3'h0 : c + 3'h1;
      if (m == 2'h2 && q[3] && !c[2])
         b = ~b;
      return {c, b};
   endfunction
   task automatic check(input logic [3:0] exp, input logic [3:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one falling step on a chosen clock, then ripple settles
   task automatic pulse(input logic on1);
      if (on1) p1 = 0;
      else p2 = 0;
      tick(2);
      p1 = 1;
      p2 = 1;
      tick(10);
      ed = step(1'b1, on1, ed);
      eb = step(1'b0, on1, eb);
      check(ed, qd);
      check(eb, qb);
   endtask
   // load held long enough that ripple falls are lost
   task automatic load(input logic [3:0] v);
      d = v;
      load_n = 0;
      tick(3);
      load_n = 1;
      tick(1);
      ed = v;
      eb = v;
      check(v, qd);
      check(v, qb);
   endtask
   // clear while the wiring is switched
   task automatic clear_to(input logic [1:0] mode);
      clear_n = 0;
      m = mode;
      tick(3);
      clear_n = 1;
      tick(1);
      ed = 4'h0;
      eb = 4'h0;
      check(ed, qd);
      check(eb, qb);
   endtask
   task automatic give_verdict();
      $display("errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      num_errors++;
      give_verdict();
   end
   // main sequence
   initial begin
      tick(2);
      rst = 0;
      for (int k = 0; k < 3; k++) begin
         clear_to(k[1:0]);
         for (int i = 0; i < 30; i++) begin
            r = rnd();
            if (i == 0 || r == 4'h9) load(i == 0 ? 4'hF : rnd());
            else pulse(m == 2'h1 || (m == 2'h0 && r[0]));
         end
      end
      // reset in mid-run with stage3 holding the first clock low
      clear_to(2'h2);
      rst = 1;
      tick(2);
      rst = 0;
      tick(3);
      check(4'h0, qd);
      check(4'h0, qb);
      clear_to(2'h0);
      load_n = 0;
      for (int i = 0; i < 6; i++) begin
         d = rnd();
         tick(2);
         check(d, qd);
      end
      load_n = 1;
      ed = d;
      d = ~d;
      tick(4);
      check(ed, qd);
      clear_n = 0;
      load_n = 0;
      tick(3);
      check(4'h0, qb);
      give_verdict();
   end
endmodule
`default_nettype wire
